// ---- rtl/adc_input_control.sv ----
// Analog input control: channel mux, gain range, trigger and transfer mode,
// pacer, conversion handshake and result registers.
// Assumes the converter runs on clk and pulses conv_done once per start.
//
// How it works
// R1: single-ended mode accepts channels zero to fifteen
// R2: differential mode accepts channels zero to seven
// R3: channel zero selected after reset
// R4: written channel latched for later conversions
// R5: high-gain variant: twelve bipolar/unipolar ranges
// R6: low-gain variant: eight ranges, gains 1-8
// R7: programmable variant: five bipolar gains, jumper base
// R8: reset selects gain one, bipolar
// R9: range changes only via range register write
// R10: mode register picks trigger and transfer
// R11: codes 0-3: ext/poll, soft/poll, timer/dma, ext/dma
// R12: codes 4-6 interrupt modes, code 7 unused
// R13: reset mode is software trigger, polled
// R14: host picks mode matching board jumpers
// R15: software trigger starts exactly one conversion
// R16: result readable at offsets four and five
// R17: ready bit goes low when result valid
// R18: result is unsigned twelve-bit code
// R19: low byte bits 7-0, high byte 11-8 plus ready
// R20: no new interrupt until host clears pending
// R21: pacer 2 MHz over two dividers, zero stops
//
// The address-and-strobe port was chosen for this implementation.
`default_nettype none

module adc_input_control
  import adc_input_control_pkg::*;
#(
  parameter variant_t VARIANT = VAR_HIGH_GAIN
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Board pins
  input wire logic ext_trig,
  input wire logic base_range_jumper,
  // Converter and front end
  output amp_cfg_t amp_cfg,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  // Transfer requests
  output logic irq_req,
  output logic dma_req
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // R11 R12: mode code split into source and transfer
  function automatic logic [1:0] trig_src(input logic [2:0] m);
    case (m)
      3'h0, 3'h3, 3'h4: trig_src = SRC_EXT;
      3'h1, 3'h5: trig_src = SRC_SOFT;
      3'h2, 3'h6: trig_src = SRC_TIMER;
      default: trig_src = SRC_NONE;
    endcase
  endfunction

  function automatic logic [1:0] xfer_of(input logic [2:0] m);
    case (m)
      3'h0, 3'h1: xfer_of = XFER_POLL;
      3'h2, 3'h3: xfer_of = XFER_DMA;
      3'h4, 3'h5, 3'h6: xfer_of = XFER_INT;
      default: xfer_of = XFER_NONE;
    endcase
  endfunction

  function automatic logic range_ok(input logic [7:0] code);
    case (VARIANT)
      VAR_HIGH_GAIN: range_ok = code < HG_RANGES;
      VAR_LOW_GAIN: range_ok = code < DG_RANGES;
      default: range_ok = code < PG_RANGES;
    endcase
  endfunction

  // Programmable variant has no unipolar ranges
  function automatic logic is_unipolar(input logic [3:0] code);
    is_unipolar = (VARIANT != VAR_PROG_GAIN) && (code >= FIRST_UNIPOLAR)
      && (code <= LAST_UNIPOLAR);
  endfunction

  function automatic logic [15:0] set_byte(input logic [15:0] old, input logic hi,
      input logic [7:0] b);
    set_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction

  ctl_state_t s_r, s_nxt;

  logic wr_div, wr_range, wr_chan, wr_mode, wr_soft, wr_clr;
  logic soft_fire, ext_fire, pacer_tick, pacer_fire, trig, pacer_run;

  assign wr_range = reg_wr && (reg_addr == OFS_RANGE);
  assign wr_chan = reg_wr && (reg_addr == OFS_MUX_SCAN);
  assign wr_mode = reg_wr && (reg_addr == OFS_MODE);
  assign wr_soft = reg_wr && (reg_addr == OFS_SOFT_TRIG);
  assign wr_clr = reg_wr && (reg_addr == OFS_CLR_IRQ);
  assign wr_div = reg_wr && (reg_addr <= OFS_DIV2_HI);

  // ----------------------------------------------------------------
  // Trigger sources
  // ----------------------------------------------------------------
  // R15: software trigger command
  assign soft_fire = wr_soft && (trig_src(s_r.mode) == SRC_SOFT);
  // Edge taken from the filtered level, so no path runs through the next state
  assign ext_fire = (s_r.ext_sync[1] == s_r.ext_sync[2]) && s_r.ext_sync[2] && !s_r.ext_lvl
    && (trig_src(s_r.mode) == SRC_EXT);
  // R21: either divider at zero halts the pacer
  assign pacer_run = (s_r.div1 != DIV_RESET) && (s_r.div2 != DIV_RESET)
    && (trig_src(s_r.mode) == SRC_TIMER);
  assign pacer_tick = pacer_run && (s_r.pre == 7'(PRESCALE_CYCLES - 1));
  assign pacer_fire = pacer_tick && (s_r.cnt1 >= s_r.div1 - 16'h0001)
    && (s_r.cnt2 >= s_r.div2 - 16'h0001);
  // Triggers landing mid-conversion are dropped, the converter cannot queue
  assign trig = (soft_fire || ext_fire || pacer_fire) && (s_r.conv == CONV_IDLE);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.dma = 1'b0;
    s_nxt.rdata = 8'h00;

    // Pins pass three stages; a level counts once stages two and three agree
    s_nxt.ext_sync = {s_r.ext_sync[1:0], ext_trig};
    if (s_r.ext_sync[1] == s_r.ext_sync[2])
    begin
      s_nxt.ext_lvl = s_r.ext_sync[2];
    end
    s_nxt.jmp_sync = {s_r.jmp_sync[1:0], base_range_jumper};
    if (s_r.jmp_sync[1] == s_r.jmp_sync[2])
    begin
      s_nxt.jmp_lvl = s_r.jmp_sync[2];
    end

    // R1 R2 R4: channel latched only when in range for the input wiring
    if (wr_chan && (reg_wdata < (s_r.diff ? DIFF_CHANNELS : SE_CHANNELS)))
    begin
      s_nxt.channel = reg_wdata[3:0];
    end
    // R9 R5 R6 R7: range code held only if the variant supports it
    if (wr_range && range_ok(reg_wdata))
    begin
      s_nxt.range_code = reg_wdata[3:0];
    end
    // R10 R12: unused mode code is refused
    if (wr_mode && (reg_wdata[7:3] == 5'h00) && (reg_wdata[2:0] != MODE_UNUSED))
    begin
      s_nxt.mode = reg_wdata[2:0];
    end
    if (reg_wr && (reg_addr == OFS_INPUT_CFG))
    begin
      s_nxt.diff = reg_wdata[0];
    end
    if (wr_div)
    begin
      case (reg_addr[1:0])
        2'h0: s_nxt.div1 = set_byte(s_r.div1, 1'b0, reg_wdata);
        2'h1: s_nxt.div1 = set_byte(s_r.div1, 1'b1, reg_wdata);
        2'h2: s_nxt.div2 = set_byte(s_r.div2, 1'b0, reg_wdata);
        default: s_nxt.div2 = set_byte(s_r.div2, 1'b1, reg_wdata);
      endcase
    end

    // R21: 2 MHz prescaler then two cascaded dividers
    if (!pacer_run || wr_div)
    begin
      s_nxt.pre = 7'h00;
      s_nxt.cnt1 = 16'h0000;
      s_nxt.cnt2 = 16'h0000;
    end
    else if (pacer_tick)
    begin
      s_nxt.pre = 7'h00;
      if (s_r.cnt1 >= s_r.div1 - 16'h0001)
      begin
        s_nxt.cnt1 = 16'h0000;
        if (s_r.cnt2 >= s_r.div2 - 16'h0001)
        begin
          s_nxt.cnt2 = 16'h0000;
        end
        else
        begin
          s_nxt.cnt2 = s_r.cnt2 + 16'h0001;
        end
      end
      else
      begin
        s_nxt.cnt1 = s_r.cnt1 + 16'h0001;
      end
    end
    else
    begin
      s_nxt.pre = s_r.pre + 7'h01;
    end

    // R20: clear first so a simultaneous completion still leaves it pending
    if (wr_clr)
    begin
      s_nxt.irq = 1'b0;
    end

    case (s_r.conv)
      CONV_IDLE:
      begin
        // R15: one start pulse per accepted trigger
        if (trig)
        begin
          s_nxt.start = 1'b1;
          s_nxt.ready_n = 1'b1;
          s_nxt.conv = CONV_WAIT;
        end
      end
      CONV_WAIT:
      begin
        if (conv_done)
        begin
          // R17 R18: result captured, ready driven low
          s_nxt.result = conv_data;
          s_nxt.ready_n = 1'b0;
          s_nxt.conv = CONV_IDLE;
          // R20: a pending request is not raised again
          if (xfer_of(s_r.mode) == XFER_INT)
          begin
            s_nxt.irq = 1'b1;
          end
          if (xfer_of(s_r.mode) == XFER_DMA)
          begin
            s_nxt.dma = 1'b1;
          end
        end
      end
      default:
      begin
        s_nxt.conv = CONV_IDLE;
      end
    endcase

    // R16 R19: read data presented the cycle after the strobe
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_RESULT_LO: s_nxt.rdata = s_r.result[7:0];
        OFS_RESULT_HI: s_nxt.rdata = {3'h0, s_r.ready_n, s_r.result[11:8]};
        OFS_STATUS: s_nxt.rdata = {4'h0, s_r.jmp_lvl, s_r.irq,
          s_r.conv == CONV_WAIT, s_r.ready_n};
        OFS_RANGE: s_nxt.rdata = {4'h0, s_r.range_code};
        OFS_MUX_SCAN: s_nxt.rdata = {4'h0, s_r.channel};
        OFS_MODE: s_nxt.rdata = {5'h00, s_r.mode};
        OFS_INPUT_CFG: s_nxt.rdata = {7'h00, s_r.diff};
        OFS_DIV1_LO: s_nxt.rdata = s_r.div1[7:0];
        OFS_DIV1_HI: s_nxt.rdata = s_r.div1[15:8];
        OFS_DIV2_LO: s_nxt.rdata = s_r.div2[7:0];
        OFS_DIV2_HI: s_nxt.rdata = s_r.div2[15:8];
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // R3 R8 R13: reset channel, range and mode
      s_r <= '{conv: CONV_IDLE, channel: CHANNEL_RESET, range_code: RANGE_RESET,
        mode: MODE_RESET, diff: 1'b0, div1: DIV_RESET, div2: DIV_RESET,
        pre: 7'h00, cnt1: 16'h0000, cnt2: 16'h0000, ready_n: 1'b1,
        result: 12'h000, irq: 1'b0, dma: 1'b0, start: 1'b0, rdata: 8'h00,
        ext_sync: 3'h0, ext_lvl: 1'b0, jmp_sync: 3'h0, jmp_lvl: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s_r.rdata;
  assign conv_start = s_r.start;
  assign irq_req = s_r.irq;
  assign dma_req = s_r.dma;
  assign amp_cfg.channel = s_r.channel;
  assign amp_cfg.range_code = s_r.range_code;
  // R5 R6: polarity follows the range code
  assign amp_cfg.unipolar = is_unipolar(s_r.range_code);
  // R7: jumper picks 5 V or 10 V base for the programmable gain
  assign amp_cfg.base_10v = s_r.jmp_lvl;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence soft_cmd_s;
    wr_soft && (trig_src(s_r.mode) == SRC_SOFT) && (s_r.conv == CONV_IDLE);
  endsequence

  sequence one_pulse_s;
    conv_start ##1 !conv_start;
  endsequence

  a_soft_trig_start: assert property (soft_cmd_s |=> one_pulse_s) // R15
    else $error("software trigger did not give one start pulse");

  a_soft_ignored_other: assert property ( // R10
    (wr_soft && (trig_src(s_r.mode) != SRC_SOFT) && !ext_fire && !pacer_fire)
      |=> !conv_start)
    else $error("software trigger started conversion outside software mode");

  a_done_ready_low: assert property ( // R17
    ((s_r.conv == CONV_WAIT) && conv_done) |=> (!s_r.ready_n
      && s_r.result == $past(conv_data)))
    else $error("completion did not capture result with ready low");

  a_result_hi_read: assert property ( // R19
    (reg_rd && reg_addr == OFS_RESULT_HI && !(s_r.conv == CONV_WAIT && conv_done))
      |=> reg_rdata == {3'h0, $past(s_r.ready_n), $past(s_r.result[11:8])})
    else $error("high result byte wrong");

  a_diff_chan_limit: assert property ( // R2
    (wr_chan && s_r.diff && reg_wdata >= DIFF_CHANNELS) |=> $stable(amp_cfg.channel))
    else $error("differential mode took an out of range channel");

  a_mode7_refused: assert property ( // R12
    (wr_mode && reg_wdata == {5'h00, MODE_UNUSED}) |=> $stable(s_r.mode))
    else $error("unused mode code was accepted");

  a_irq_held: assert property (irq_req && !wr_clr |=> irq_req) // R20
    else $error("interrupt request dropped without clear");

  a_pacer_zero_stop: assert property ( // R21
    ((trig_src(s_r.mode) == SRC_TIMER) && (s_r.div1 == DIV_RESET || s_r.div2 == DIV_RESET))
      |=> !conv_start)
    else $error("pacer fired with a zero divider");

  a_range_refused: assert property ( // R9
    (wr_range && !range_ok(reg_wdata)) |=> $stable(amp_cfg.range_code))
    else $error("unsupported range code was accepted");

  a_chan_latched: assert property ( // R4
    (wr_chan && (reg_wdata < (s_r.diff ? DIFF_CHANNELS : SE_CHANNELS)))
      |=> (amp_cfg.channel == $past(reg_wdata[3:0])))
    else $error("valid channel write was not latched");

  a_mode_taken: assert property ( // R10
    (wr_mode && (reg_wdata < 8'h07)) |=> (s_r.mode == $past(reg_wdata[2:0])))
    else $error("valid mode code was not taken");

  a_irq_set_wins: assert property ( // R20
    ((s_r.conv == CONV_WAIT) && conv_done && (xfer_of(s_r.mode) == XFER_INT)) |=> irq_req)
    else $error("completion in interrupt mode gave no request");

  a_irq_cleared: assert property ( // R20
    (wr_clr && !((s_r.conv == CONV_WAIT) && conv_done)) |=> !irq_req)
    else $error("clear access left the request pending");

  // One request per result, never a level
  sequence dma_pulse_s;
    dma_req ##1 !dma_req;
  endsequence

  a_dma_one_pulse: assert property ( // R11
    ((s_r.conv == CONV_WAIT) && conv_done && (xfer_of(s_r.mode) == XFER_DMA))
      |=> dma_pulse_s)
    else $error("completion in transfer mode gave no single request");

endmodule

`default_nettype wire

// ---- include/adc_input_control_pkg.sv ----
// Constants, register map and state types for the analog input control block.
// Assumes a byte-wide register port and a converter on the same clock.
`default_nettype none

package adc_input_control_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_DIV1_LO = 5'h00;
  localparam logic [4:0] OFS_DIV1_HI = 5'h01;
  localparam logic [4:0] OFS_DIV2_LO = 5'h02;
  localparam logic [4:0] OFS_DIV2_HI = 5'h03;
  localparam logic [4:0] OFS_RESULT_LO = 5'h04;
  localparam logic [4:0] OFS_RESULT_HI = 5'h05;
  localparam logic [4:0] OFS_STATUS = 5'h06;
  localparam logic [4:0] OFS_CLR_IRQ = 5'h08;
  localparam logic [4:0] OFS_RANGE = 5'h09;
  localparam logic [4:0] OFS_MUX_SCAN = 5'h0a;
  localparam logic [4:0] OFS_MODE = 5'h0b;
  localparam logic [4:0] OFS_SOFT_TRIG = 5'h0c;
  localparam logic [4:0] OFS_INPUT_CFG = 5'h0d;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HI_READY_N_BIT = 4;
  localparam int ST_READY_N_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_IRQ_BIT = 2;
  localparam int ST_BASE10_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CHANNEL_RESET = 4'h0;
  localparam logic [3:0] RANGE_RESET = 4'h0;
  localparam logic [2:0] MODE_RESET = 3'h1;
  localparam logic [15:0] DIV_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam logic [7:0] SE_CHANNELS = 8'h10;
  localparam logic [7:0] DIFF_CHANNELS = 8'h08;
  localparam logic [7:0] HG_RANGES = 8'h0c;
  localparam logic [7:0] DG_RANGES = 8'h08;
  localparam logic [7:0] PG_RANGES = 8'h05;
  localparam logic [3:0] FIRST_UNIPOLAR = 4'h4;
  localparam logic [3:0] LAST_UNIPOLAR = 4'h7;
  localparam int CLK_HZ = 250_000_000;
  localparam int PACER_BASE_HZ = 2_000_000;
  localparam int PRESCALE_CYCLES = CLK_HZ / PACER_BASE_HZ;

  // ----------------------------------------------------------------
  // Modes: trigger source and transfer method
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_SOFT = 2'h1;
  localparam logic [1:0] SRC_TIMER = 2'h2;
  localparam logic [1:0] SRC_NONE = 2'h3;
  localparam logic [1:0] XFER_POLL = 2'h0;
  localparam logic [1:0] XFER_DMA = 2'h1;
  localparam logic [1:0] XFER_INT = 2'h2;
  localparam logic [1:0] XFER_NONE = 2'h3;
  localparam logic [2:0] MODE_UNUSED = 3'h7;

  typedef enum logic [1:0] {VAR_HIGH_GAIN, VAR_LOW_GAIN, VAR_PROG_GAIN} variant_t;

  typedef enum logic {CONV_IDLE, CONV_WAIT} conv_state_t;

  // Amplifier and multiplexer settings toward the analog front end
  typedef struct packed {
    logic [3:0] channel;
    logic [3:0] range_code;
    logic unipolar;
    logic base_10v;
  } amp_cfg_t;

  typedef struct packed {
    conv_state_t conv;
    logic [3:0] channel;
    logic [3:0] range_code;
    logic [2:0] mode;
    logic diff;
    logic [15:0] div1;
    logic [15:0] div2;
    logic [6:0] pre;
    logic [15:0] cnt1;
    logic [15:0] cnt2;
    logic ready_n;
    logic [11:0] result;
    logic irq;
    logic dma;
    logic start;
    logic [7:0] rdata;
    logic [2:0] ext_sync;
    logic ext_lvl;
    logic [2:0] jmp_sync;
    logic jmp_lvl;
  } ctl_state_t;

endpackage

`default_nettype wire

// ---- dv/conv_model.sv ----
// Behavioural converter facing the analog input control block.
// Assumes one start pulse per conversion and the same clock as the block.
`default_nettype none

module conv_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Converter handshake
  input wire logic conv_start,
  output logic conv_done,
  output logic [11:0] conv_data,
  // Bench side
  output logic [11:0] last_data,
  output var int starts
);
  timeunit 1ns;
  timeprecision 100ps;

  integer seed = 32'hd3214459;
  logic [3:0] cnt;
  logic [11:0] d;

  // Data toggles outside the done cycle so a stale sample is caught
  // twelve-bit result
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt <= 4'h0;
      d <= 12'h000;
      conv_done <= 1'b0;
      conv_data <= 12'h000;
      last_data <= 12'h000;
      starts <= 0;
    end
    else
    begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      // Result drawn ahead so it is handed over without a blocking step
      d <= 12'($random(seed));
      if (conv_start)
      begin
        starts <= starts + 1;
        cnt <= 4'h1 + 4'($unsigned($random(seed)) % 8);
      end
      else if (cnt == 4'h1)
      begin
        cnt <= 4'h0;
        conv_done <= 1'b1;
        conv_data <= d;
        last_data <= d;
      end
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
endmodule

`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the analog input control block.
// Assumes the high-gain variant and the converter model on the far side.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_input_control_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic ext_trig = 1'b0;
  logic base_range_jumper = 1'b0;
  amp_cfg_t amp_cfg;
  logic conv_start, conv_done, irq_req, dma_req;
  logic [11:0] conv_data, last_data;
  int starts;
  int dma_cnt = 0;
  int fails = 0;
  int comparisons = 0;
  integer seed = 32'hd3214459;

  always #2 clk = ~clk;

  adc_input_control #(.VARIANT(VAR_HIGH_GAIN)) u_adc_input_control (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_trig(ext_trig),
    .base_range_jumper(base_range_jumper), .amp_cfg(amp_cfg), .conv_start(conv_start),
    .conv_done(conv_done), .conv_data(conv_data), .irq_req(irq_req), .dma_req(dma_req));

  conv_model u_conv_model (
    .clk(clk), .rst(rst), .conv_start(conv_start), .conv_done(conv_done),
    .conv_data(conv_data), .last_data(last_data), .starts(starts));

  always @(posedge clk)
    if (dma_req === 1'b1)
      dma_cnt <= dma_cnt + 1;

  // ----------------------------------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------------------------------
  function automatic int soft_ok(input int m);
    return (m == 1 || m == 5);
  endfunction
  function automatic int ext_ok(input int m);
    return (m == 0 || m == 3 || m == 4);
  endfunction
  function automatic int dma_on(input int m);
    return (m == 2 || m == 3);
  endfunction
  function automatic int irq_on(input int m);
    return (m >= 4 && m <= 6);
  endfunction

  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Register reads have their own compare
  task automatic chk_reg(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    comparisons++;
    if (d !== exp)
    begin
      fails++;
      $display("[FAIL] reg %h expected %h seen %h", a, exp, d);
    end
  endtask

  task automatic wait_ready();
    logic [7:0] s;
    int n;
    n = 0;
    s = 8'h01;
    while (s[ST_READY_N_BIT] !== 1'b0 && n < 50)
    begin
      rd(OFS_STATUS, s);
      n++;
    end
    chk("ready_n", 16'h0000, {15'h0, s[ST_READY_N_BIT]});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int i, m, em, prev, n0, n1, d0;
    logic [7:0] v;
    logic [3:0] cur;
    logic diff;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("channel", 16'h0, {12'h0, amp_cfg.channel});
    chk("range", 16'h0, {12'h0, amp_cfg.range_code});
    chk("unipolar", 16'h0, {15'h0, amp_cfg.unipolar});
    chk_reg(OFS_STATUS, 8'h01);
    chk_reg(5'h1f, 8'h00);
    $display("test reset done");

    cur = 4'h0;
    diff = 1'b0;
    for (i = 0; i < 40; i++)
    begin
      if (i == 20)
      begin
        wr(OFS_INPUT_CFG, 8'h01);
        diff = 1'b1;
      end
      if (i % 20 == 0)
        v = diff ? 8'h08 : 8'h10;
      else if (i % 20 == 1)
        v = diff ? 8'h07 : 8'h0f;
      else
        v = 8'($random(seed)) & 8'h1f;
      wr(OFS_MUX_SCAN, v);
      if (v < (diff ? DIFF_CHANNELS : SE_CHANNELS))
        cur = v[3:0];
      chk("channel", {12'h0, cur}, {12'h0, amp_cfg.channel});
    end
    wr(OFS_INPUT_CFG, 8'h00);
    $display("test channel done");

    cur = 4'h0;
    for (i = 0; i < 18; i++)
    begin
      v = (i < 16) ? 8'(i) : 8'($random(seed));
      wr(OFS_RANGE, v);
      if (v < HG_RANGES)
        cur = v[3:0];
      chk("range", {12'h0, cur}, {12'h0, amp_cfg.range_code});
      chk("unipolar", {15'h0, cur >= FIRST_UNIPOLAR && cur <= LAST_UNIPOLAR},
          {15'h0, amp_cfg.unipolar});
    end
    $display("test range done");

    for (i = 0; i < 8; i++)
    begin
      n0 = starts;
      wr(OFS_SOFT_TRIG, 8'h00);
      wait_ready();
      chk("starts", 16'(n0 + 1), 16'(starts));
      chk_reg(OFS_RESULT_LO, last_data[7:0]);
      chk_reg(OFS_RESULT_HI, {4'h0, last_data[11:8]});
    end
    $display("test soft conversion done");

    prev = 1;
    for (m = 0; m < 8; m++)
    begin
      em = (m == 7) ? prev : m;
      wr(OFS_MODE, 8'(m));
      wr(OFS_CLR_IRQ, 8'h00);
      n0 = starts;
      d0 = dma_cnt;
      wr(OFS_SOFT_TRIG, 8'h00);
      idle(30);
      n1 = starts;
      ext_trig <= 1'b1;
      idle(10);
      ext_trig <= 1'b0;
      idle(30);
      chk("soft start", 16'(soft_ok(em)), 16'(n1 - n0));
      chk("ext start", 16'(ext_ok(em)), 16'(starts - n1));
      chk("dma", 16'(dma_on(em) * (starts - n0)), 16'(dma_cnt - d0));
      chk("irq", 16'(irq_on(em) && starts != n0), {15'h0, irq_req});
      prev = em;
    end
    $display("test modes done");

    wr(OFS_MODE, 8'h05);
    wr(OFS_CLR_IRQ, 8'h00);
    wr(OFS_SOFT_TRIG, 8'h00);
    idle(30);
    wr(OFS_SOFT_TRIG, 8'h00);
    idle(30);
    chk("irq held", 16'h1, {15'h0, irq_req});
    chk_reg(OFS_STATUS, 8'h04);
    wr(OFS_CLR_IRQ, 8'h00);
    chk("irq clear", 16'h0, {15'h0, irq_req});
    $display("test interrupt done");

    wr(OFS_MODE, 8'h06);
    wr(OFS_DIV1_LO, 8'h01);
    wr(OFS_DIV2_LO, 8'h02);
    n0 = starts;
    idle(800);
    chk("pacer", 16'h3, 16'(starts - n0));
    wr(OFS_DIV1_LO, 8'h00);
    n0 = starts;
    idle(800);
    chk("pacer stop", 16'h0, 16'(starts - n0));
    base_range_jumper <= 1'b1;
    idle(8);
    chk("jumper", 16'h1, {15'h0, amp_cfg.base_10v});
    $display("test pacer and jumper done");
    stop_test();
  end

  // Whole run is near 2600 cycles; this leaves ample margin
  initial
  begin
    #100000;
    fails++;
    stop_test();
  end
endmodule

`default_nettype wire
